// >>> hw/dio_consts.vh
// Constants for the direct I/O command unit.
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH
`define CHR_CLEAR_TP 8'h58
`define CHR_READ_IN 8'h4e
`define CHR_LOAD_MASK 8'h4c
`define CHR_REINIT 8'h42
`define CHR_TP_ON 8'h51
`define CHR_SLASH 8'h2f
`define CHR_LF 8'h0a
`define CLK_HZ 20000000
`define TICK_HZ 1000000
`define MS_US 1000
`define PULSE_US 4
`define SAMPLE_US 2
`define MASK_RST 4'h0
`endif

// >>> hw/us_divider.v
// Divider that makes the 1 MHz and 1 ms enable pulses.
`timescale 1ns/10ps
module us_divider #(
  parameter US_DIV = 20,
  parameter MS_DIV = 1000
) (
  input wire clk, // System clock.
  input wire rst_n, // Asynchronous reset, active low.
  output reg us_tick, // One-cycle pulse each microsecond.
  output reg ms_tick // One-cycle pulse each millisecond.
);
  reg [7:0] us_cnt_q;
  reg [15:0] ms_cnt_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_q <= 8'h00;
      ms_cnt_q <= 16'h0000;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
      if (us_cnt_q == US_DIV[7:0] - 8'h01) begin
        us_cnt_q <= 8'h00;
        us_tick <= 1'b1;
        if (ms_cnt_q == MS_DIV[15:0] - 16'h0001) begin
          ms_cnt_q <= 16'h0000;
          ms_tick <= 1'b1;
        end else begin
          ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
      end else begin
        us_cnt_q <= us_cnt_q + 8'h01;
      end
    end
  end
endmodule

// >>> hw/direct_io_command_unit.v
// Direct I/O command interpreter with sync strobe and output pulses.
`timescale 1ns/10ps
`include "dio_consts.vh"
module direct_io_command_unit #(
  parameter PULSE_US = `PULSE_US,
  parameter SAMPLE_US = `SAMPLE_US
) (
  input wire clk, // 20 MHz clock.
  input wire rst_n, // Asynchronous reset, active low.
  input wire [7:0] port_wr_data, // Byte written to the byte transfer port.
  input wire port_wr, // Write strobe, one cycle.
  input wire port_rd, // Read strobe, one cycle.
  output reg [7:0] byte_transfer_port, // Output buffer contents.
  output reg buf_full, // Output buffer holds unread data.
  input wire [3:0] ext_input_lines, // External inputs, low is true.
  output reg [3:0] ext_output_lines, // External output pulses, high active.
  output reg sync_n, // Sync strobe, low during a pulse.
  input wire [3:0] timed_pulse_req, // Timed unit pulse requests per output line.
  output reg tp_active // Clock chip test point active.
);
  localparam US_DIV = `CLK_HZ / `TICK_HZ;
  // One-hot parser states: waiting for a command, skipping comment bytes, expecting the mask.
  localparam S_IDLE = 3'b001;
  localparam S_DELIM = 3'b010;
  localparam S_MASK = 3'b100;

  wire us_tick;
  wire ms_tick;
  reg [3:0] in_s1_q;
  reg [3:0] in_s2_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] mask_q;
  reg [3:0] mask_d;
  reg tp_d;
  reg [3:0] dio_cnt_q;
  reg [3:0] dio_cnt_d;
  reg [3:0] ms_cnt_q;
  reg [3:0] ms_cnt_d;
  reg [3:0] timed_q;
  reg [3:0] timed_d;
  reg [3:0] timed_pend_q;
  reg [3:0] timed_pend_d;

  wire [3:0] line_on;
  wire [3:0] code_now;
  wire dio_busy = (dio_cnt_q != 4'h0);
  wire ms_busy = (ms_cnt_q != 4'h0);
  wire is_delim = (port_wr_data == `CHR_SLASH) || (port_wr_data == `CHR_LF);
  // A read request is honoured only as a command, never as a mask or comment byte.
  wire n_start = port_wr && (state_q == S_IDLE) && (port_wr_data == `CHR_READ_IN) && !dio_busy;
  wire sample_now = dio_busy && us_tick && (dio_cnt_q == SAMPLE_US[3:0]);

  us_divider #(.US_DIV(US_DIV), .MS_DIV(`MS_US)) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .us_tick(us_tick),
    .ms_tick(ms_tick)
  );

  // Inputs come from pins, so they are synchronised before sampling. The flops reset to the
  // idle (high, false) level so a read just after reset does not report every line true.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_q <= 4'hf;
      in_s2_q <= 4'hf;
    end else begin
      in_s1_q <= ext_input_lines;
      in_s2_q <= in_s1_q;
    end
  end

  // Next-state decode of the command parser; one byte is taken per write strobe.
  always @* begin
    state_d = state_q;
    mask_d = mask_q;
    tp_d = tp_active;
    if (port_wr) begin
      case (state_q)
        S_IDLE: begin
          if (port_wr_data == `CHR_LOAD_MASK) begin
            state_d = S_DELIM;
          end else if (port_wr_data == `CHR_CLEAR_TP) begin
            tp_d = 1'b0;
          end else if (port_wr_data == `CHR_TP_ON) begin
            tp_d = 1'b1;
          end else if (port_wr_data == `CHR_REINIT) begin
            mask_d = `MASK_RST;
          end
        end
        S_DELIM: begin
          // Comment bytes are skipped until a delimiter arrives; a byte slipped in after
          // the delimiter would be taken as the mask, so the host must not send one.
          if (is_delim) begin
            state_d = S_MASK;
          end
        end
        S_MASK: begin
          // Any byte is the mask here, even a command letter or a delimiter.
          mask_d = port_wr_data[3:0];
          state_d = S_IDLE;
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  // Command parser registers.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      mask_q <= `MASK_RST;
      tp_active <= 1'b0;
    end else begin
      state_q <= state_d;
      mask_q <= mask_d;
      tp_active <= tp_d;
    end
  end

  // Direct I/O pulse: starts on the N byte, not aligned to the millisecond. A second N that
  // arrives while the pulse runs is dropped rather than stretching the pulse. The width is
  // counted in whole microsecond ticks, so it lasts between PULSE_US-1 and PULSE_US us.
  always @* begin
    dio_cnt_d = dio_cnt_q;
    if (n_start) begin
      dio_cnt_d = PULSE_US[3:0];
    end else if (dio_busy && us_tick) begin
      dio_cnt_d = dio_cnt_q - 4'h1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dio_cnt_q <= 4'h0;
    end else begin
      dio_cnt_q <= dio_cnt_d;
    end
  end

  // Millisecond sync pulse and tick-aligned timed output pulses. Requests are held pending
  // until the next millisecond tick, so a short request is never lost between ticks.
  always @* begin
    ms_cnt_d = ms_cnt_q;
    timed_d = timed_q;
    timed_pend_d = timed_pend_q | timed_pulse_req;
    if (ms_tick) begin
      ms_cnt_d = PULSE_US[3:0];
      timed_d = timed_pend_q | timed_pulse_req;
      timed_pend_d = 4'h0;
    end else begin
      if (ms_busy && us_tick) begin
        ms_cnt_d = ms_cnt_q - 4'h1;
      end
      if (ms_cnt_q == 4'h1 && us_tick) begin
        timed_d = 4'h0;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= 4'h0;
      timed_q <= 4'h0;
      timed_pend_q <= 4'h0;
    end else begin
      ms_cnt_q <= ms_cnt_d;
      timed_q <= timed_d;
      timed_pend_q <= timed_pend_d;
    end
  end

  // One slice per output line: the line follows its mask bit during a direct pulse and its
  // timed request during the millisecond pulse. Input code bits are inverted per line here.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_line
      assign line_on[gi] = (dio_busy & mask_q[gi]) | timed_q[gi];
      assign code_now[gi] = ~in_s2_q[gi];
    end
  endgenerate

  // Output buffer: the sample is taken mid-pulse, while sync is low. A sample that lands in
  // the same cycle as a host read wins, so a fresh code is never thrown away unseen.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_transfer_port <= 8'h00;
      buf_full <= 1'b0;
      sync_n <= 1'b1;
      ext_output_lines <= 4'h0;
    end else begin
      sync_n <= !(dio_busy || ms_busy);
      ext_output_lines <= line_on;
      if (sample_now) begin
        byte_transfer_port <= {4'h0, code_now};
        buf_full <= 1'b1;
      end else if (port_rd) begin
        byte_transfer_port <= 8'h00;
        buf_full <= 1'b0;
      end
    end
  end
endmodule

// >>> test/dio_properties.sv
// Port checker for the direct I/O command unit.
`timescale 1ns/10ps
module dio_properties #(
  parameter PULSE_US = 4,
  parameter SAMPLE_US = 2
) (
  input wire clk, // Clock.
  input wire rst_n, // Reset.
  input wire [7:0] port_wr_data, // Byte in.
  input wire port_wr, // Write strobe.
  input wire port_rd, // Read strobe.
  input wire [7:0] byte_transfer_port, // Buffer.
  input wire buf_full, // Buffer full.
  input wire [3:0] ext_input_lines, // Inputs.
  input wire [3:0] ext_output_lines, // Outputs.
  input wire sync_n, // Sync strobe.
  input wire [3:0] timed_pulse_req, // Timed requests.
  input wire tp_active // Test point.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Tracks the parser phase from the byte stream, so a mask byte that happens to equal a
  // command letter is not taken for that command.
  reg [1:0] ph_q;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      ph_q <= 2'h0;
    else if (port_wr)
      ph_q <= (ph_q == 2'h0) ? ((port_wr_data == 8'h4c) ? 2'h1 : 2'h0) :
              (ph_q == 2'h1) ? ((port_wr_data == 8'h2f || port_wr_data == 8'h0a) ? 2'h2 : 2'h1) :
              2'h0;
  wire cmd_wr = port_wr && ph_q == 2'h0;
  wire n_req = cmd_wr && port_wr_data == 8'h4e;
  reg [15:0] hi_q;
  // Counts idle sync cycles; a missing millisecond strobe lets it run past the period.
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      hi_q <= 16'h0000;
    else
      hi_q <= sync_n ? hi_q + 16'h0001 : 16'h0000;
  a_x_clears_tp: assert property (cmd_wr && port_wr_data == 8'h58 |=> !tp_active)
    else $error("test point left active");
  a_n_drives_sync: assert property (n_req |-> ##[1:3] !sync_n)
    else $error("no sync after read request");
  a_n_pulse_width: assert property (n_req && sync_n |-> ##2 !sync_n [*8])
    else $error("direct pulse too short");
  a_out_with_sync: assert property (ext_output_lines != 4'h0 |-> !sync_n)
    else $error("output pulse without sync");
  a_code_high_zero: assert property (byte_transfer_port[7:4] == 4'h0)
    else $error("upper code bits set");
  a_read_clears: assert property (port_rd && !n_req |=> !buf_full && byte_transfer_port == 8'h00)
    else $error("read left buffer full");
  a_buf_fills: assert property (n_req && sync_n |-> ##[2:100] buf_full)
    else $error("code never buffered");
  a_ms_strobe: assert property (hi_q < 16'h4e40)
    else $error("millisecond strobe missing");
endmodule
bind direct_io_command_unit dio_properties #(.PULSE_US(PULSE_US), .SAMPLE_US(SAMPLE_US)) i_props (.*);

// >>> test/host_model.sv
// Host model that writes and reads the byte transfer port.
`timescale 1ns/10ps
module host_model (
  input wire clk, // Clock.
  output logic [7:0] port_wr_data, // Byte to the unit.
  output logic port_wr, // Write strobe.
  output logic port_rd // Read strobe.
);
  initial begin
    port_wr_data = 8'h00;
    port_wr = 1'b0;
    port_rd = 1'b0;
  end
  // Released data shows the inverse, so a stale byte never looks valid.
  task send(input logic [7:0] b);
    @(posedge clk);
    port_wr <= 1'b1;
    port_wr_data <= b;
    @(posedge clk);
    port_wr <= 1'b0;
    port_wr_data <= ~b;
  endtask
  task rd;
    @(posedge clk);
    port_rd <= 1'b1;
    @(posedge clk);
    port_rd <= 1'b0;
  endtask
  task load_mask(input logic [7:0] m, input logic slash);
    send(8'h4c);
    send(8'h69);
    send(slash ? 8'h2f : 8'h0a);
    send(m);
  endtask
endmodule

// >>> test/tb.sv
// Randomised self-checking bench for the direct I/O command unit.
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] port_wr_data, byte_transfer_port, mb;
  logic port_wr, port_rd, buf_full, sync_n, tp_active;
  logic [3:0] ext_input_lines = 4'hf, timed_pulse_req = 4'h0, ext_output_lines, in;
  integer seed = 32'hc6f4bd19, mismatches = 0, num_checks = 0, k;
  always #25 clk = ~clk;
  host_model i_host (.clk(clk), .port_wr_data(port_wr_data), .port_wr(port_wr), .port_rd(port_rd));
  direct_io_command_unit i_dut (.*);
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function logic [7:0] code(input logic [3:0] lines);
    code = {4'h0, ~lines};
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task read_in(input logic [3:0] msk);
    @(posedge clk);
    in = $random(seed);
    ext_input_lines <= in;
    i_host.send(8'h4e);
    repeat (4) @(posedge clk);
    #1 chk({4'h0, ext_output_lines}, {4'h0, msk});
    chk({7'h00, sync_n}, 8'h00);
    repeat (90) @(posedge clk);
    #1 chk(byte_transfer_port, code(in));
    chk({7'h00, buf_full}, 8'h01);
    i_host.rd;
    @(posedge clk);
    #1 chk({7'h00, buf_full}, 8'h00);
    chk(byte_transfer_port, 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    read_in(4'h0);
    for (k = 0; k < 6; k++) begin
      mb = $random(seed);
      i_host.load_mask(mb, k[0]);
      read_in(mb[3:0]);
      read_in(mb[3:0]);
    end
    i_host.load_mask(8'h38, 1'b1);
    read_in(4'h8);
    i_host.send(8'h42);
    read_in(4'h0);
    i_host.send(8'h51);
    #1 chk({7'h00, tp_active}, 8'h01);
    i_host.send(8'h58);
    @(posedge clk);
    #1 chk({7'h00, tp_active}, 8'h00);
    @(posedge clk);
    timed_pulse_req <= 4'h5;
    @(posedge clk);
    timed_pulse_req <= 4'h0;
    k = 0;
    while (ext_output_lines == 4'h0 && k < 21000) begin
      @(posedge clk);
      #1 k++;
    end
    chk({4'h0, ext_output_lines}, 8'h05);
    chk({7'h00, sync_n}, 8'h00);
    repeat (100) @(posedge clk);
    #1 chk({4'h0, ext_output_lines}, 8'h00);
    chk({7'h00, sync_n}, 8'h01);
    repeat (19899) @(posedge clk);
    #1 chk({7'h00, sync_n}, 8'h01);
    @(posedge clk);
    #1 chk({7'h00, sync_n}, 8'h00);
    chk({4'h0, ext_output_lines}, 8'h00);
    print_verdict;
  end
  initial begin
    #(60000 * 50);
    mismatches++;
    print_verdict;
  end
endmodule
